/* verilog/i2c_master_seq.sv */
// two-wire master sequencer with register port and receive fifo
`timescale 1ns/100ps
`default_nettype none

module rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic                       clk_in,
   input  wire logic                       nrst_in,
   input  wire logic                       in_valid_in,
   output logic                            in_ready_out,
   input  wire logic [WIDTH-1:0]           in_data_in,
   output logic                            out_valid_out,
   input  wire logic                       out_ready_in,
   output logic [WIDTH-1:0]                out_data_out,
   output logic [$clog2(DEPTH+1)-1:0]      count_out
);
   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [IW-1:0]    wr_idx;
   logic [IW-1:0]    rd_idx;
   logic [CW-1:0]    count;
   wire              push = in_valid_in & in_ready_out;
   wire              pop  = out_valid_out & out_ready_in;

   // depth is a power of two so the indices wrap by themselves
   assign in_ready_out  = count != CW'(DEPTH);
   assign out_valid_out = count != '0;
   assign out_data_out  = mem[rd_idx];
   assign count_out     = count;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         wr_idx <= wr_idx + IW'(push);
         rd_idx <= rd_idx + IW'(pop);
         count  <= count + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_idx] <= in_data_in;
      end
   end
endmodule

module i2c_master_seq
   import i2c_seq_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic [1:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [15:0]      rdata_out,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_out,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out
);
   logic [15:0]           ctrl;
   logic [15:0]           rdata;
   logic                  scl_meta;
   logic                  scl_hi;
   logic                  sda_meta;
   logic                  sda_hi;
   logic [7:0]            q_cnt;
   seq_state_t            state;
   logic [2:0]            phase;
   logic [2:0]            bit_cnt;
   logic [DATA_W-1:0]     shreg;
   logic                  owned;
   lines_t                lines;
   lines_t                next_lines;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic [DATA_W-1:0]     fifo_out_data;
   logic [FIFO_CNT_W-1:0] fifo_count;

   // {scl_low, sda_low} for every quarter of every sequence; PH_END is the hold after
   function automatic lines_t line_val(seq_state_t s, logic [2:0] ph, logic ackv);
      logic a;
      a = ~ackv;
      unique case (s)
         SEQ_START:   line_val = (ph == PH_FIRST) ? 2'b00 : (ph == PH_LAST || ph == PH_END)
                                 ? 2'b11 : 2'b01;
         SEQ_RESTART: line_val = (ph == PH_FIRST) ? 2'b10 : (ph == 3'h1) ? 2'b00
                                 : (ph == PH_SAMPLE) ? 2'b01 : 2'b11;
         SEQ_STOP:    line_val = (ph == PH_FIRST) ? 2'b11 : (ph == 3'h1) ? 2'b01 : 2'b00;
         SEQ_RECV:    line_val = (ph == 3'h1 || ph == PH_SAMPLE) ? 2'b00 : 2'b10;
         SEQ_ACK:     line_val = (ph == PH_END) ? 2'b10 : {(ph == PH_FIRST || ph == PH_LAST), a};
         SEQ_IDLE:    line_val = 2'b00;
      endcase
   endfunction

   // one-hot position of the go bit that belongs to a sequence
   function automatic logic [15:0] go_bit(seq_state_t s);
      unique case (s)
         SEQ_START:   go_bit = 16'h0001;
         SEQ_RESTART: go_bit = 16'h0002;
         SEQ_STOP:    go_bit = 16'h0004;
         SEQ_RECV:    go_bit = 16'h0008;
         SEQ_ACK:     go_bit = 16'h0010;
         SEQ_IDLE:    go_bit = 16'h0000;
      endcase
   endfunction

   ctrl_t cf;
   assign cf = ctrl_t'(ctrl);

   wire [4:0]  go      = ctrl[4:0];
   wire        idle    = state == SEQ_IDLE;
   wire        qtick   = q_cnt == QUARTER_LAST;
   // a released clock that a target still holds low stalls the phase advance; the quarter count keeps running
   wire        held    = ~lines.scl_low & ~scl_hi;
   wire        advance = qtick & ~idle & ~held;
   wire        last_q  = phase == PH_LAST;
   wire        done    = advance & last_q & (state != SEQ_RECV || bit_cnt == BIT_LAST);
   wire        sample  = advance & (state == SEQ_RECV) & (phase == PH_SAMPLE);
   wire        push    = done & (state == SEQ_RECV);
   wire        stretch_hold = cf.slave_stretch_enable & ~cf.clock_line_release;
   seq_state_t pick;
   assign pick = go[0] ? SEQ_START : go[1] ? SEQ_RESTART : go[2] ? SEQ_STOP
               : go[3] ? SEQ_RECV : SEQ_ACK;
   // a full fifo stalls a new receive instead of dropping a byte
   wire        start_seq = idle & cf.enable & ~cf.management_protocol_enable & (|go)
                         & (pick != SEQ_RECV || fifo_in_ready);
   wire [2:0]  ld_ph   = done ? PH_END : last_q ? PH_FIRST : phase + 3'h1;

   // go bits are taken only while idle or in the cycle a sequence finishes, and a set beats the clear
   wire        wr_ctrl = wr_in & (addr_in == CTRL_ADDR);
   wire        cfg_ok  = idle | done;
   wire [15:0] wmask   = wr_ctrl ? (ANY_MASK | (cfg_ok ? CFG_MASK : 16'h0000)) : 16'h0000;
   wire [15:0] clr16   = done ? go_bit(state) : 16'h0000;
   wire [15:0] set16   = (wr_ctrl & cfg_ok) ? (wdata_in & GO_MASK) : 16'h0000;
   wire [15:0] next_ctrl = (ctrl & ~wmask & ~clr16) | (wdata_in & wmask) | set16;

   wire        pop     = rd_in & (addr_in == RXDATA_ADDR) & fifo_out_valid;
   wire [15:0] status  = {9'h000, fifo_count, owned, ~idle, scl_hi, sda_hi};
   wire [15:0] rx_word = fifo_out_valid ? {8'h00, fifo_out_data} : 16'h0000;
   wire [15:0] next_rdata = ~rd_in ? 16'h0000
                          : (addr_in == CTRL_ADDR)   ? ctrl
                          : (addr_in == RXDATA_ADDR) ? rx_word
                          : (addr_in == STATUS_ADDR) ? status : 16'h0000;

   always_comb begin
      next_lines = lines;
      if (start_seq) begin
         next_lines = line_val(pick, PH_FIRST, cf.acknowledge_value);
      end else if (advance) begin
         next_lines = line_val(state, ld_ph, cf.acknowledge_value);
      end else if (idle && !owned) begin
         next_lines = '{scl_low: stretch_hold, sda_low: 1'b0};
      end
   end

   rx_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (shreg),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (pop),
      .out_data_out  (fifo_out_data),
      .count_out     (fifo_count)
   );

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_meta <= 1'b1;
         scl_hi   <= 1'b1;
         sda_meta <= 1'b1;
         sda_hi   <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_hi   <= scl_meta;
         sda_meta <= sda_in;
         sda_hi   <= sda_meta;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl   <= CTRL_RST;
         rdata  <= 16'h0000;
         lines  <= '0;
         q_cnt  <= 8'h00;
      end else begin
         ctrl   <= next_ctrl;
         rdata  <= next_rdata;
         lines  <= next_lines;
         q_cnt  <= qtick ? 8'h00 : q_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= SEQ_IDLE;
         phase <= PH_FIRST;
      end else begin
         state <= start_seq ? pick : done ? SEQ_IDLE : state;
         phase <= (start_seq || (advance && last_q)) ? PH_FIRST
                : advance ? phase + 3'h1 : phase;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bit_cnt <= 3'h0;
         shreg   <= '0;
         owned   <= 1'b0;
      end else begin
         bit_cnt <= start_seq ? 3'h0 : (advance && last_q) ? bit_cnt + 3'h1 : bit_cnt;
         shreg   <= sample ? {shreg[DATA_W-2:0], sda_hi} : shreg;
         owned   <= (done && state == SEQ_START) ? 1'b1
                  : (done && state == SEQ_STOP) ? 1'b0 : owned;
      end
   end

   // open-drain: pins are only ever pulled low
   assign scl_out    = 1'b0;
   assign sda_out    = 1'b0;
   assign scl_oe_out = lines.scl_low;
   assign sda_oe_out = lines.sda_low;
   assign rdata_out  = rdata;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   chk_stretch_hold: assert property (
      (idle && !owned && !start_seq) |=> (scl_oe_out == $past(stretch_hold)))
      else $error("clock stretch hold does not follow stretch enable and release");
   chk_ack_level: assert property (
      (state == SEQ_ACK) |-> (sda_oe_out == !cf.acknowledge_value))
      else $error("acknowledge level differs from acknowledge value");
   chk_ack_clear: assert property (
      $fell(cf.acknowledge_sequence_go) |-> ($past(state) == SEQ_ACK && idle))
      else $error("acknowledge go cleared outside the end of the sequence");
   chk_recv_byte: assert property (
      $fell(cf.byte_receive_go) |-> ($past(bit_cnt) == BIT_LAST && $past(push)))
      else $error("receive go cleared before the eighth bit");
   chk_stop_lines: assert property (
      $fell(cf.stop_sequence_go) |-> (!sda_oe_out && !scl_oe_out && !owned))
      else $error("stop finished without releasing both lines");
   chk_restart_end: assert property (
      $fell(cf.restart_sequence_go) |-> ($past(state) == SEQ_RESTART && sda_oe_out && scl_oe_out))
      else $error("repeated start did not end with both lines low");
   chk_start_end: assert property (
      (state == SEQ_START && done) |=> (!cf.start_sequence_go && owned && sda_oe_out && scl_oe_out))
      else $error("start did not end with lines low and go cleared");
   chk_go_active: assert property (
      (!idle) |-> ((ctrl & go_bit(state)) != 16'h0000))
      else $error("running sequence has its go bit clear");
   chk_quarter_len: assert property (
      (advance && !done) |=> (!advance) [*8])
      else $error("quarter periods follow each other too fast");
   // bus levels per phase; a held clock only lengthens a phase, never reorders it
   chk_start_fall: assert property (
      (state == SEQ_START && (phase == 3'h1 || phase == PH_SAMPLE))
      |-> (sda_oe_out && !scl_oe_out))
      else $error("start did not pull data low under a released clock");
   chk_restart_fall: assert property (
      (state == SEQ_RESTART && phase == PH_SAMPLE) |-> (sda_oe_out && !scl_oe_out))
      else $error("repeated start did not pull data low under a released clock");
   chk_stop_rise: assert property (
      (state == SEQ_STOP && phase == PH_SAMPLE) |-> (!sda_oe_out && !scl_oe_out))
      else $error("stop did not release data under a released clock");
   chk_ack_pulse: assert property (
      (state == SEQ_ACK && phase == 3'h1) |-> !scl_oe_out)
      else $error("acknowledge clock pulse missing");
   chk_ack_release: assert property (
      (state == SEQ_ACK && done) |=> (scl_oe_out && !sda_oe_out))
      else $error("acknowledge did not end with clock low and data free");
   chk_recv_release: assert property (
      (state == SEQ_RECV) |-> !sda_oe_out)
      else $error("master drives data during a receive");
   chk_recv_shift: assert property (
      sample |-> (!scl_oe_out && !sda_oe_out))
      else $error("receive sampled data without a released clock");
   chk_recv_stall: assert property (
      (idle && pick == SEQ_RECV && !fifo_in_ready) |=> idle)
      else $error("receive started with the fifo full");
   chk_master_blocked: assert property (
      (idle && (cf.management_protocol_enable || !cf.enable)) |=> idle)
      else $error("sequence started while blocked by the control bits");
   chk_owned_start: assert property (
      $rose(owned) |-> ($past(state) == SEQ_START))
      else $error("bus marked owned without a start");
endmodule

`default_nettype wire

/* verilog/i2c_seq_pkg.sv */
// constants, layouts and state codes for the two-wire master sequencer
// Overview of operation
// - slave stretch enable with clock release low holds the clock line low while idle and the bus is not owned.
// - acknowledge sequence drives acknowledge value: 1 sends NACK, 0 sends ACK.
// - acknowledge go runs an acknowledge clock pulse; hardware clears it at the end.
// - receive go clocks in one byte; hardware clears it after the eighth bit.
// - stop go makes a Stop condition; hardware clears it when done.
// - restart go makes a Repeated Start; hardware clears it when done.
// - start go makes a Start condition; hardware clears it when done.
package i2c_seq_pkg;
   localparam logic [1:0]  CTRL_ADDR    = 2'h0;
   localparam logic [1:0]  RXDATA_ADDR  = 2'h1;
   localparam logic [1:0]  STATUS_ADDR  = 2'h2;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          QUARTER_NS   = 2500;
   localparam int          QUARTER_CYC  = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  QUARTER_LAST = 8'(QUARTER_CYC - 1);
   localparam int          DATA_W       = 8;
   localparam int          FIFO_DEPTH   = 4;
   localparam int          FIFO_CNT_W   = 3;
   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam logic [2:0]  PH_FIRST     = 3'h0;
   localparam logic [2:0]  PH_SAMPLE    = 3'h2;
   localparam logic [2:0]  PH_LAST      = 3'h3;
   localparam logic [2:0]  PH_END       = 3'h4;
   localparam logic [15:0] CTRL_RST     = 16'h1000;
   localparam logic [15:0] ANY_MASK     = 16'h9840;
   localparam logic [15:0] CFG_MASK     = 16'h0020;
   localparam logic [15:0] GO_MASK      = 16'h001F;

   typedef struct packed {
      logic       enable;
      logic [1:0] rsv_hi;
      logic       clock_line_release;
      logic       management_protocol_enable;
      logic [3:0] rsv_mid;
      logic       slave_stretch_enable;
      logic       acknowledge_value;
      logic       acknowledge_sequence_go;
      logic       byte_receive_go;
      logic       stop_sequence_go;
      logic       restart_sequence_go;
      logic       start_sequence_go;
   } ctrl_t;

   typedef struct packed {
      logic scl_low;
      logic sda_low;
   } lines_t;

   typedef enum logic [2:0] {
      SEQ_IDLE    = 3'h0,
      SEQ_START   = 3'h1,
      SEQ_RECV    = 3'h3,
      SEQ_ACK     = 3'h2,
      SEQ_STOP    = 3'h6,
      SEQ_RESTART = 3'h7
   } seq_state_t;
endpackage

/* tb/i2c_target_model.sv */
// two-wire bus target model that serves bytes to the master
`timescale 1ns/100ps
`default_nettype none

module i2c_target_model (
   input  wire logic scl_oe_in,
   input  wire logic sda_oe_in,
   input  wire logic hold_scl_in,
   output logic      scl_out,
   output logic      sda_out,
   output logic      last_bit_out,
   output int        starts_out,
   output int        stops_out
);
   logic [7:0] bytes [5] = '{8'hA5, 8'h3C, 8'hF0, 8'h01, 8'h96};
   logic [3:0] bitn      = 4'hF;
   logic [2:0] byten     = 3'h0;
   logic       drv;
   logic       armed     = 1'b0;

   initial begin
      starts_out   = 0;
      stops_out    = 0;
      last_bit_out = 1'b1;
      // edges out of the unknown power-up level are no bus conditions
      #100 armed = 1'b1;
   end
   // released lines float to the pull-up level; out of bytes the data line is let go
   assign drv     = (byten < 3'h5) && (bitn < 4'h8) && !bytes[byten][3'h7 - bitn[2:0]];
   assign scl_out = !(scl_oe_in || hold_scl_in);
   assign sda_out = !(sda_oe_in || drv);
   always @(negedge sda_out) begin
      if (scl_out && armed) begin
         starts_out++;
         bitn = 4'hF;
      end
   end
   always @(posedge sda_out) begin
      if (scl_out && armed) stops_out++;
   end
   always @(posedge scl_out) begin
      last_bit_out = sda_out;
   end
   // next data bit appears only while the clock is low
   always @(negedge scl_out) begin
      if (bitn == 4'h7) begin
         bitn = 4'h0;
         byten++;
      end else bitn = bitn + 4'h1;
   end
endmodule

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import i2c_seq_pkg::*;
   logic        clk_in = 1'b0;
   logic        nrst_in;
   logic [1:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic        hold;
   logic [15:0] rdata;
   logic [15:0] r;
   logic        scl_oe;
   logic        sda_oe;
   logic        scl_pin;
   logic        sda_pin;
   logic        scl_lvl;
   logic        sda_lvl;
   logic        last_bit;
   int          starts;
   int          stops;
   int          fails;
   int          num_checks;

   i2c_master_seq i2c_master_seq_i (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .scl_in(scl_pin),
      .scl_out(scl_lvl), .scl_oe_out(scl_oe), .sda_in(sda_pin), .sda_out(sda_lvl),
      .sda_oe_out(sda_oe));
   i2c_target_model i2c_target_model_i (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
      .hold_scl_in(hold), .scl_out(scl_pin), .sda_out(sda_pin), .last_bit_out(last_bit),
      .starts_out(starts), .stops_out(stops));

   initial begin
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded poll so a stuck go bit cannot hang the run
   task automatic wait_go(input logic [15:0] m);
      int n;
      n = 0;
      r = m;
      while ((r & m) !== 16'h0 && n < 20000) begin
         rd_reg(CTRL_ADDR, r);
         n++;
      end
      chk("go bit cleared", 16'h0, r & m);
   endtask

   task automatic t_reset;
      chk("oe after reset", 16'h0, 16'({scl_oe, sda_oe}));
      chk("pin drive level", 16'h0, 16'({scl_lvl, sda_lvl}));
      rd_reg(CTRL_ADDR, r);
      chk("ctrl reset", CTRL_RST, r);
      rd_reg(STATUS_ADDR, r);
      chk("status idle", 16'h0003, r);
      rd_reg(2'h3, r);
      chk("unmapped", 16'h0, r);
      rd_reg(RXDATA_ADDR, r);
      chk("rx empty", 16'h0, r);
   endtask
   task automatic t_stretch;
      wr_reg(CTRL_ADDR, 16'h0040);
      cyc(3);
      chk("clock held", 16'h1, 16'(scl_oe));
      wr_reg(CTRL_ADDR, 16'h1040);
      cyc(3);
      chk("clock released", 16'h0, 16'(scl_oe));
      wr_reg(CTRL_ADDR, 16'h0000);
      cyc(3);
      chk("stretch off", 16'h0, 16'(scl_oe));
   endtask
   task automatic t_start;
      wr_reg(CTRL_ADDR, 16'h9801);
      cyc(600);
      rd_reg(CTRL_ADDR, r);
      chk("start pending", 16'h9801, r);
      chk("no start yet", 16'h0, 16'(starts));
      wr_reg(CTRL_ADDR, 16'h1001);
      cyc(600);
      rd_reg(CTRL_ADDR, r);
      chk("start held by enable", 16'h1001, r);
      chk("still no start", 16'h0, 16'(starts));
      wr_reg(CTRL_ADDR, 16'h9001);
      wait_go(16'h0001);
      chk("start seen", 16'h1, 16'(starts));
      rd_reg(STATUS_ADDR, r);
      chk("bus owned", 16'h0008, r & 16'h0008);
      chk("start lines", 16'h3, 16'({scl_oe, sda_oe}));
   endtask
   task automatic t_receive;
      logic [7:0] exp [4] = '{8'hA5, 8'h3C, 8'hF0, 8'h01};
      for (int i = 0; i < 4; i++) begin
         wr_reg(CTRL_ADDR, 16'h9008);
         if (i == 1) begin
            hold <= 1'b1;
            cyc(1500);
            hold <= 1'b0;
         end
         wait_go(16'h0008);
      end
      rd_reg(STATUS_ADDR, r);
      chk("fifo full", 16'h0040, r & 16'h0070);
      wr_reg(CTRL_ADDR, 16'h9008);
      cyc(2000);
      rd_reg(CTRL_ADDR, r);
      chk("receive waits", 16'h9008, r);
      for (int i = 0; i < 4; i++) begin
         rd_reg(RXDATA_ADDR, r);
         chk("rx byte", {8'h00, exp[i]}, r);
      end
      wait_go(16'h0008);
      rd_reg(RXDATA_ADDR, r);
      chk("rx last byte", 16'h0096, r);
   endtask
   task automatic t_ack(input logic v);
      wr_reg(CTRL_ADDR, 16'h9010 | {10'h0, v, 5'h0});
      cyc(400);
      chk("ack drive", 16'(!v), 16'(sda_oe));
      wait_go(16'h0010);
      chk("ack on bus", 16'(v), 16'(last_bit));
   endtask
   task automatic t_restart_stop;
      wr_reg(CTRL_ADDR, 16'h9002);
      wait_go(16'h0002);
      chk("restart seen", 16'h2, 16'(starts));
      wr_reg(CTRL_ADDR, 16'h9004);
      wait_go(16'h0004);
      chk("stop seen", 16'h1, 16'(stops));
      cyc(3);
      rd_reg(STATUS_ADDR, r);
      chk("bus free", 16'h0003, r & 16'h000F);
      chk("lines free", 16'h0, 16'({scl_oe, sda_oe}));
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      // about 80k cycles; the scenarios need roughly 50k
      #800000;
      fails++;
      test_done;
   end
   initial begin
      addr       = 2'h0;
      wdata      = 16'h0;
      wr         = 1'b0;
      rd         = 1'b0;
      hold       = 1'b0;
      nrst_in    = 1'b0;
      fails      = 0;
      num_checks = 0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset;
      t_stretch;
      t_start;
      t_receive;
      t_ack(1'b0);
      t_ack(1'b1);
      t_restart_stop;
      test_done;
   end
endmodule

`default_nettype wire
